// [logic/pcs_cfg.svh]
/*
  constants for the phy configuration and self-id link logic: offsets,
  field positions, reset values and codes.
  assumes: included by the design modules by bare name.
*/
// Overview of operation
// - marker code eh replaced by 0h
// - config packet identifier field is 00
// - force-root flag selects root node id
// - gap-update flag loads gap count value
// - new gap count applies at once, survives reset
// - second reset without packet restores 3fh
// - both flags clear: packet ignored
// - destination select picks broadcast or bulky fifo
// - ack code 0001b good, 1101b error
// - lone node: header and ack only
// - no ack quadlet in broadcast fifo
// - header 0000_00e0h then quadlet and inverse
// - bulky fifo gets ack quadlet first
// - extended index selects port range
// - index 3 to 7 port fields reserved
// - more flag, changed sender means lost packet
// - port status two-bit coding
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define PCS_OFF_CTRL 12'h148
`define PCS_OFF_TXQ 12'h000
`define PCS_OFF_STAT 12'h004
`define PCS_OFF_BROADCAST_WRITE_RX_FIFO 12'h008
`define PCS_OFF_BULKY_ASYNC_RX_FIFO 12'h00c
`define PCS_OFF_GAP 12'h010

// ----------------------------------------------------------------
// fields and values
// ----------------------------------------------------------------
`define PCS_BIT_DEST_SEL 21
`define PCS_CTRL_RESET 32'h0000_0000
`define PCS_MARKER_HI 31
`define PCS_MARKER_LO 28
`define PCS_MARKER_TX 4'he
`define PCS_MARKER_PHY 4'h0
`define PCS_GAP_DEFAULT 6'h3f
`define PCS_GAP_RESET_VAL 8'h63
`define PCS_ACK_GOOD 4'h1
`define PCS_ACK_ERR 4'hd
`define PCS_SID_HEADER 32'h0000_00e0
`define PCS_ACK_BASE 32'h0000_8000
`define PCS_FIFO_DEPTH 16
`define PCS_FIFO_AW 4

`endif

// [logic/pcs_fifo.sv]
/*
  word fifo used for the two self-id receive queues.
  assumes: single clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "pcs_cfg.svh"
module pcs_fifo import pcs_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_in,
  input wire logic [31:0] wdata_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic empty_out,
  output logic full_out
);
  // storage array
  logic [31:0] mem_q [`PCS_FIFO_DEPTH];
  logic [`PCS_FIFO_AW:0] wp_q;
  logic [`PCS_FIFO_AW:0] rp_q;

  assign empty_out = (wp_q == rp_q);
  assign full_out = (wp_q[`PCS_FIFO_AW] != rp_q[`PCS_FIFO_AW]) &&
                    (wp_q[`PCS_FIFO_AW-1:0] == rp_q[`PCS_FIFO_AW-1:0]);
  assign rdata_out = mem_q[rp_q[`PCS_FIFO_AW-1:0]];

  // write side
  always_ff @(posedge clk_in) begin
    if (wr_in && !full_out) begin
      mem_q[wp_q[`PCS_FIFO_AW-1:0]] <= wdata_in;
    end
  end

  // pointers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (wr_in && !full_out) wp_q <= wp_q + 1'b1;
      if (rd_in && !empty_out) rp_q <= rp_q + 1'b1;
    end
  end
endmodule : pcs_fifo

// [logic/pcs_gap.sv]
/*
  gap count keeper: applies configuration packets seen on the bus and
  restores the default after two resets without a new gap update.
  assumes: strobes come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "pcs_cfg.svh"
module pcs_gap import pcs_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cfg_in,
  input wire logic [31:0] cfg_q_in,
  input wire logic [5:0] my_node_in,
  input wire logic bus_reset_in,
  output logic [5:0] gap_out,
  output logic force_root_out
);
  // resets seen since the last gap-update packet
  logic [1:0] rst_cnt_q;
  logic r_flag;
  logic t_flag;
  assign r_flag = cfg_q_in[23];
  assign t_flag = cfg_q_in[22];

  // gap count and force-root state
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      gap_out <= `PCS_GAP_DEFAULT;
      force_root_out <= 1'b0;
      rst_cnt_q <= 2'd0;
    end else if (cfg_in && cfg_q_in[31:30] == 2'b00 && (r_flag || t_flag)) begin
      if (r_flag) force_root_out <= (cfg_q_in[29:24] == my_node_in);
      if (t_flag) begin
        gap_out <= cfg_q_in[21:16];
        rst_cnt_q <= 2'd0;
      end
    end else if (bus_reset_in) begin
      if (rst_cnt_q == 2'd1) gap_out <= `PCS_GAP_DEFAULT;
      if (rst_cnt_q != 2'd2) rst_cnt_q <= rst_cnt_q + 2'd1;
    end
  end

  AST_GAP_REV: assert property (@(posedge clk_in) disable iff (rst_in)
    bus_reset_in && !cfg_in && rst_cnt_q == 2'd1 |=> gap_out == `PCS_GAP_DEFAULT)
    else $error("gap not restored");
  AST_GAP_LOAD: assert property (@(posedge clk_in) disable iff (rst_in)
    cfg_in && cfg_q_in[31:30] == 2'b00 && t_flag |=> gap_out == $past(cfg_q_in[21:16]))
    else $error("gap not loaded");
  AST_GAP_RSV: assert property (@(posedge clk_in) disable iff (rst_in)
    cfg_in && !r_flag && !t_flag && !bus_reset_in |=> $stable(gap_out) && $stable(force_root_out))
    else $error("reserved packet acted on");
endmodule : pcs_gap

// [logic/pcs_link.sv]
/*
  phy configuration transmit and self-id receive sorting, with an
  ahb-lite register slave.
  assumes: phy-side strobes come from logic on CLK_IN; host is ahb master.
*/
`timescale 1ns/1ps
`include "pcs_cfg.svh"
module pcs_link import pcs_pkg::*; (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  output logic PHY_TX_VALID_OUT,
  output logic [31:0] PHY_TX_DATA_OUT,
  input wire logic PHY_RX_VALID_IN,
  input wire logic PHY_RX_FIRST_IN,
  input wire logic [31:0] PHY_RX_DATA_IN,
  input wire logic PHY_RX_ERR_IN,
  input wire logic PHY_SID_END_IN,
  input wire logic PHY_BUS_RESET_IN,
  input wire logic [5:0] NODE_ID_IN,
  output logic [5:0] GAP_COUNT_OUT,
  output logic FORCE_ROOT_OUT
);
  // ----------------------------------------------------------------
  // ahb address phase capture
  // ----------------------------------------------------------------
  logic dp_act_q;
  logic dp_wr_q;
  logic [11:0] dp_addr_q;
  logic [31:0] ctrl_q;
  logic tx_idx_q;
  logic [7:0] lost_cnt_q;
  pcs_rxq_t rx;
  pcs_sid_st_t st_q;
  logic [31:0] sid_q;
  logic sid_err_q;
  logic sid_more_q;
  logic [5:0] sid_node_q;
  logic wr_bw;
  logic wr_ba;
  logic [31:0] wd_bw;
  logic [31:0] wd_ba;
  logic rd_bw;
  logic rd_ba;
  logic [31:0] bw_dat;
  logic [31:0] ba_dat;
  logic bw_empty;
  logic ba_empty;
  logic bw_full;
  logic ba_full;
  logic ack_pend_q;
  logic [5:0] gap_w;
  logic root_w;
  logic cfg_seen;
  logic [7:0] conn_cnt_q;
  // bulky queue holds self-ids back so the ack quadlet can lead
  logic [31:0] sid_buf_q [8];
  logic [3:0] buf_cnt_q;
  logic buf_wr;
  logic drain_q;
  logic [3:0] drain_idx_q;

  // ack quadlet from a code
  function automatic logic [31:0] ack_quad(input logic err);
    ack_quad = `PCS_ACK_BASE | {28'h0, (err ? `PCS_ACK_ERR : `PCS_ACK_GOOD)};
  endfunction : ack_quad

  // connected ports: high bit of a status pair set
  function automatic logic [3:0] conn_ports(input logic [31:0] q);
    conn_ports = 4'h0;
    for (int i = 0; i < 8; i++) conn_ports = conn_ports + {3'h0, q[2 * i + 3]};
  endfunction : conn_ports

  assign rx = '{valid: PHY_RX_VALID_IN, first: PHY_RX_FIRST_IN, data: PHY_RX_DATA_IN};

  // address phase register
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      dp_act_q <= 1'b0;
      dp_wr_q <= 1'b0;
      dp_addr_q <= 12'h000;
    end else if (HREADY_IN) begin
      dp_act_q <= HSEL_IN && HTRANS_IN[1];
      dp_wr_q <= HWRITE_IN;
      dp_addr_q <= HADDR_IN[11:0];
    end
  end

  // slave always zero wait, okay
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
    end else begin
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      ctrl_q <= `PCS_CTRL_RESET;
    end else if (dp_act_q && dp_wr_q && dp_addr_q == `PCS_OFF_CTRL) begin
      ctrl_q <= HWDATA_IN;
    end
  end

  // read data, registered in the address phase for a zero-wait reply
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      HRDATA_OUT <= 32'h0000_0000;
    end else if (HREADY_IN && HSEL_IN && HTRANS_IN[1] && !HWRITE_IN) begin
      unique case (HADDR_IN[11:0])
        `PCS_OFF_CTRL: HRDATA_OUT <= ctrl_q;
        `PCS_OFF_STAT: HRDATA_OUT <= {lost_cnt_q, 8'h00, conn_cnt_q, 4'h0, ba_full,
                                      ba_empty, bw_full, bw_empty};
        `PCS_OFF_BROADCAST_WRITE_RX_FIFO: HRDATA_OUT <= bw_dat;
        `PCS_OFF_BULKY_ASYNC_RX_FIFO: HRDATA_OUT <= ba_dat;
        `PCS_OFF_GAP: HRDATA_OUT <= {25'h0, root_w, gap_w};
        default: HRDATA_OUT <= 32'h0000_0000;
      endcase
    end
  end

  // fifo pops on read address phase
  assign rd_bw = HREADY_IN && HSEL_IN && HTRANS_IN[1] && !HWRITE_IN &&
                 HADDR_IN[11:0] == `PCS_OFF_BROADCAST_WRITE_RX_FIFO;
  assign rd_ba = HREADY_IN && HSEL_IN && HTRANS_IN[1] && !HWRITE_IN &&
                 HADDR_IN[11:0] == `PCS_OFF_BULKY_ASYNC_RX_FIFO;

  // ----------------------------------------------------------------
  // phy configuration transmit
  // ----------------------------------------------------------------
  // two-quadlet request, marker rewrite
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      tx_idx_q <= 1'b0;
      PHY_TX_VALID_OUT <= 1'b0;
      PHY_TX_DATA_OUT <= 32'h0000_0000;
    end else begin
      PHY_TX_VALID_OUT <= 1'b0;
      if (dp_act_q && dp_wr_q && dp_addr_q == `PCS_OFF_TXQ) begin
        PHY_TX_VALID_OUT <= 1'b1;
        PHY_TX_DATA_OUT <= HWDATA_IN;
        if (!tx_idx_q && HWDATA_IN[`PCS_MARKER_HI:`PCS_MARKER_LO] == `PCS_MARKER_TX) begin
          PHY_TX_DATA_OUT[`PCS_MARKER_HI:`PCS_MARKER_LO] <= `PCS_MARKER_PHY;
        end
        tx_idx_q <= ~tx_idx_q;
      end
    end
  end

  AST_MARKER: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    dp_act_q && dp_wr_q && dp_addr_q == `PCS_OFF_TXQ && !tx_idx_q &&
    HWDATA_IN[31:28] == 4'he |=> PHY_TX_VALID_OUT && PHY_TX_DATA_OUT[31:28] == 4'h0)
    else $error("marker not rewritten");

  // ----------------------------------------------------------------
  // self-id receive sorting
  // ----------------------------------------------------------------
  // config packet on the bus: first quadlet with identifier 00
  assign cfg_seen = rx.valid && rx.first && st_q == PCS_IDLE && rx.data[31:30] == 2'b00;

  // self-id capture, header then quadlet and inverse
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      st_q <= PCS_IDLE;
      sid_q <= 32'h0;
      sid_err_q <= 1'b0;
      ack_pend_q <= 1'b0;
      sid_more_q <= 1'b0;
      sid_node_q <= 6'h0;
      lost_cnt_q <= 8'h0;
      conn_cnt_q <= 8'h0;
    end else begin
      ack_pend_q <= 1'b0;
      unique case (st_q)
        PCS_IDLE: begin
          if (PHY_BUS_RESET_IN) begin
            st_q <= PCS_QUAD;
            sid_err_q <= 1'b0;
            sid_more_q <= 1'b0;
            conn_cnt_q <= 8'h0;
          end
        end
        PCS_QUAD: begin
          if (PHY_SID_END_IN) begin
            st_q <= PCS_IDLE;
            ack_pend_q <= 1'b1;
          end else if (rx.valid) begin
            sid_q <= rx.data;
            if (sid_more_q && rx.data[29:24] != sid_node_q) lost_cnt_q <= lost_cnt_q + 8'd1;
            sid_node_q <= rx.data[29:24];
            sid_more_q <= rx.data[0];
            // extended index 0 to 2 only, 3 to 7 reserved
            if (rx.data[23] && rx.data[22:20] <= 3'd2) begin
              conn_cnt_q <= conn_cnt_q + {4'h0, conn_ports(rx.data)};
            end
            st_q <= PCS_INV;
          end
        end
        PCS_INV: begin
          if (rx.valid) begin
            if (rx.data != ~sid_q || PHY_RX_ERR_IN) sid_err_q <= 1'b1;
            st_q <= PCS_QUAD;
          end
        end
        default: st_q <= PCS_IDLE;
      endcase
    end
  end

  // destination select, ack placement, no ack in bw
  always_comb begin
    wr_bw = 1'b0;
    wr_ba = 1'b0;
    wd_bw = rx.data;
    wd_ba = rx.data;
    if (st_q == PCS_IDLE && PHY_BUS_RESET_IN) begin
      wd_bw = `PCS_SID_HEADER;
      wr_bw = ctrl_q[`PCS_BIT_DEST_SEL];
    end else if (st_q != PCS_IDLE && rx.valid && !PHY_SID_END_IN) begin
      wr_bw = ctrl_q[`PCS_BIT_DEST_SEL];
    end
    if (ack_pend_q && !ctrl_q[`PCS_BIT_DEST_SEL]) begin
      wr_ba = 1'b1;
      wd_ba = ack_quad(sid_err_q);
    end else if (drain_q) begin
      wr_ba = 1'b1;
      wd_ba = (drain_idx_q == 4'h0) ? `PCS_SID_HEADER : sid_buf_q[3'(drain_idx_q - 4'h1)];
    end
  end

  // self-ids bound for the bulky queue wait until the ack code is known
  assign buf_wr = st_q != PCS_IDLE && rx.valid && !PHY_SID_END_IN &&
                  !ctrl_q[`PCS_BIT_DEST_SEL] && buf_cnt_q != 4'd8;

  // hold store of eight quadlets, drained after the ack
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      buf_cnt_q <= 4'h0;
      drain_q <= 1'b0;
      drain_idx_q <= 4'h0;
    end else if (st_q == PCS_IDLE && PHY_BUS_RESET_IN) begin
      // new phase drops whatever was left
      buf_cnt_q <= 4'h0;
      drain_q <= 1'b0;
    end else if (ack_pend_q && !ctrl_q[`PCS_BIT_DEST_SEL]) begin
      drain_q <= 1'b1;
      drain_idx_q <= 4'h0;
    end else if (drain_q) begin
      // header at index 0, last item out when index meets count
      if (drain_idx_q == buf_cnt_q) drain_q <= 1'b0;
      drain_idx_q <= drain_idx_q + 4'h1;
    end else if (buf_wr) begin
      sid_buf_q[buf_cnt_q[2:0]] <= rx.data;
      buf_cnt_q <= buf_cnt_q + 4'h1;
    end
  end

  AST_NO_ACK_BW: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    ack_pend_q && ctrl_q[21] |-> !wr_bw)
    else $error("ack written to broadcast queue");
  AST_ACK_CODE: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    ack_pend_q && !ctrl_q[21] |-> wd_ba[3:0] == (sid_err_q ? 4'hd : 4'h1))
    else $error("bad ack code");
  AST_ACK_FIRST: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    ack_pend_q && !ctrl_q[21] && !PHY_BUS_RESET_IN |=> wr_ba && wd_ba == 32'h0000_00e0)
    else $error("header does not follow ack");

  pcs_fifo u_bw (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .wr_in(wr_bw),
    .wdata_in(wd_bw),
    .rd_in(rd_bw),
    .rdata_out(bw_dat),
    .empty_out(bw_empty),
    .full_out(bw_full)
  );

  pcs_fifo u_ba (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .wr_in(wr_ba),
    .wdata_in(wd_ba),
    .rd_in(rd_ba),
    .rdata_out(ba_dat),
    .empty_out(ba_empty),
    .full_out(ba_full)
  );

  // ----------------------------------------------------------------
  // gap count and force root
  // ----------------------------------------------------------------
  pcs_gap u_gap (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .cfg_in(cfg_seen),
    .cfg_q_in(rx.data),
    .my_node_in(NODE_ID_IN),
    .bus_reset_in(PHY_BUS_RESET_IN),
    .gap_out(gap_w),
    .force_root_out(root_w)
  );

  // registered copies for the pins
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      GAP_COUNT_OUT <= `PCS_GAP_DEFAULT;
      FORCE_ROOT_OUT <= 1'b0;
    end else begin
      GAP_COUNT_OUT <= gap_w;
      FORCE_ROOT_OUT <= root_w;
    end
  end
endmodule : pcs_link

// [logic/pcs_pkg.sv]
/*
  types shared by the phy configuration and self-id link logic.
  assumes: pcs_cfg.svh supplies the numeric constants.
*/
package pcs_pkg;
  // phy-side receive quadlet with its framing
  typedef struct packed {
    logic valid;
    logic first;
    logic [31:0] data;
  } pcs_rxq_t;

  // self-id capture states
  typedef enum logic [1:0] {
    PCS_IDLE = 2'b00,
    PCS_QUAD = 2'b01,
    PCS_INV = 2'b10
  } pcs_sid_st_t;
endpackage : pcs_pkg

// [tb/pcs_link_tb.sv]
/*
  self-checking bench: config transmit, gap count keeping, self-id sorting.
  assumes: zero-wait ahb slave; phy model on the same clock.
*/
`timescale 1ns/1ps
module pcs_link_tb;
  logic clk, rst, hsel, hwrite, hreadyout, hresp, tx_valid;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, tx_data, rx_data;
  logic rx_valid, rx_first, rx_err, sid_end, bus_reset, froot;
  logic [5:0] gap;
  logic [31:0] tx_seen [$]; // quadlets handed to the phy
  int miscompares, samples_checked;

  pcs_link pcs_link_i (.CLK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
    .HREADY_IN(hreadyout), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hreadyout),
    .HRESP_OUT(hresp), .PHY_TX_VALID_OUT(tx_valid), .PHY_TX_DATA_OUT(tx_data),
    .PHY_RX_VALID_IN(rx_valid), .PHY_RX_FIRST_IN(rx_first), .PHY_RX_DATA_IN(rx_data),
    .PHY_RX_ERR_IN(rx_err), .PHY_SID_END_IN(sid_end), .PHY_BUS_RESET_IN(bus_reset),
    .NODE_ID_IN(6'h05), .GAP_COUNT_OUT(gap), .FORCE_ROOT_OUT(froot));
  pcs_phy_model pcs_phy_model_i (.clk_in(clk), .rx_valid_out(rx_valid),
    .rx_first_out(rx_first), .rx_data_out(rx_data), .rx_err_out(rx_err),
    .sid_end_out(sid_end), .bus_reset_out(bus_reset));

  // ----------------------------------------------------------------
  // clock, capture and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // collect every transmitted quadlet
  always @(posedge clk) begin
    if (tx_valid === 1'b1) tx_seen.push_back(tx_data);
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one ahb single transfer; waits on hready in both phases
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] v;
    ahb(1'b1, a, d, v);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    chk(v, exp);
  endtask : rd

  task automatic do_reset();
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask : do_reset

  // config packet from the bus, first quadlet then its inverse
  task automatic cfg_rx(input logic r, input logic t, input logic [5:0] root,
                        input logic [5:0] g);
    logic [31:0] q;
    q = {2'b00, root, r, t, g, 16'h0000};
    pcs_phy_model_i.send_q(q, 1'b1, 1'b0);
    pcs_phy_model_i.send_q(~q, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
  endtask : cfg_rx

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(32'h148, 32'h0000_0000);
    rd(32'h020, 32'h0000_0000);
    wr(32'h148, 32'h0020_0000);
    rd(32'h148, 32'h0020_0000);
    chk(gap, 6'h3f);
    rd(32'h010, 32'h0000_003f);
  endtask : t_regs

  task automatic t_tx();
    // host sends exactly two quadlets, marker first
    wr(32'h000, 32'he12a_3456);
    wr(32'h000, 32'h5a5a_0f0f);
    repeat (3) @(posedge clk);
    chk(tx_seen.size(), 2);
    chk(tx_seen[0], 32'h012a_3456);
    chk(tx_seen[0][31:30], 2'b00);
    chk(tx_seen[1], 32'h5a5a_0f0f);
  endtask : t_tx

  task automatic t_gap();
    logic [31:0] none [4];
    none = '{default: 32'h0};
    do_reset();
    cfg_rx(1'b0, 1'b1, 6'h00, 6'h2a);
    chk(gap, 6'h2a);
    pcs_phy_model_i.sid_phase(none, 0, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    chk(gap, 6'h2a);
    pcs_phy_model_i.sid_phase(none, 0, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    chk(gap, 6'h3f);
    cfg_rx(1'b1, 1'b0, 6'h05, 6'h11);
    chk({froot, gap}, {1'b1, 6'h3f});
    cfg_rx(1'b1, 1'b0, 6'h09, 6'h11);
    chk(froot, 1'b0);
    cfg_rx(1'b0, 1'b0, 6'h05, 6'h11);
    chk({froot, gap}, {1'b0, 6'h3f});
  endtask : t_gap

  // self-id phase with n packets; dest picks the queue
  task automatic t_sid(input logic dest, input int n, input logic err, input logic bad);
    logic [31:0] qs [4];
    logic [31:0] a, v;
    // extended, reserved index 4, more flag set
    qs[0] = {2'b10, 6'd1, 1'b1, 3'd4, 2'b00, 16'hffff, 2'b01};
    // new sender, index 1, four ports connected
    qs[1] = {2'b10, 6'd2, 1'b1, 3'd1, 2'b00, 16'hfa50, 2'b00};
    qs[2] = 32'h8344_aa50;
    qs[3] = 32'h8444_aa50;
    a = dest ? 32'h008 : 32'h00c;
    do_reset();
    wr(32'h148, {10'h000, dest, 21'h000000});
    pcs_phy_model_i.sid_phase(qs, n, err, bad);
    repeat (4) @(posedge clk);
    if (!dest) rd(a, {28'h0000_800, (err | bad) ? 4'hd : 4'h1});
    rd(a, 32'h0000_00e0);
    for (int k = 0; k < n; k++) begin
      rd(a, qs[k]);
      rd(a, bad ? ~qs[k] ^ 32'h0000_0001 : ~qs[k]);
    end
    ahb(1'b0, 32'h004, 32'h0, v);
    chk({v[2], v[0]}, 2'b11);
    chk(v[31:24], (n > 1) ? 8'h01 : 8'h00);
    chk(v[15:8], (n > 1) ? 8'h04 : 8'h00);
  endtask : t_sid

  // ----------------------------------------------------------------
  // main sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    do_reset();
    t_regs();
    t_tx();
    t_gap();
    t_sid(1'b1, 2, 1'b0, 1'b0);
    t_sid(1'b0, 0, 1'b0, 1'b0);
    t_sid(1'b0, 1, 1'b1, 1'b0);
    t_sid(1'b0, 1, 1'b0, 1'b1);
    print_verdict();
  end

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #400000;
    miscompares++;
    print_verdict();
  end
endmodule : pcs_link_tb

// [tb/pcs_phy_model.sv]
/*
  phy-side model: sends received quadlets, bus reset and end of self-id.
  assumes: the testbench calls its tasks; every strobe moves on clk_in.
*/
`timescale 1ns/1ps
module pcs_phy_model (
  input wire logic clk_in,
  output logic rx_valid_out,
  output logic rx_first_out,
  output logic [31:0] rx_data_out,
  output logic rx_err_out,
  output logic sid_end_out,
  output logic bus_reset_out
);
  // idle levels at time zero
  initial begin
    rx_valid_out = 1'b0;
    rx_first_out = 1'b0;
    rx_data_out = 32'h0000_0000;
    rx_err_out = 1'b0;
    sid_end_out = 1'b0;
    bus_reset_out = 1'b0;
  end

  // one quadlet for one cycle; data line inverted once released
  task automatic send_q(input logic [31:0] d, input logic f, input logic e);
    @(posedge clk_in);
    rx_valid_out <= 1'b1;
    rx_first_out <= f;
    rx_data_out <= d;
    rx_err_out <= e;
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    rx_first_out <= 1'b0;
    rx_err_out <= 1'b0;
    rx_data_out <= ~d;
  endtask : send_q

  // one packet each
  // bus reset, n self-id packets with inverses, then end of phase
  task automatic sid_phase(input logic [31:0] qs [4], input int n, input logic err,
                           input logic bad);
    @(posedge clk_in);
    bus_reset_out <= 1'b1;
    @(posedge clk_in);
    bus_reset_out <= 1'b0;
    for (int k = 0; k < n; k++) begin
      send_q(qs[k], 1'b1, 1'b0);
      // bad inverse only when a scenario asks for it
      send_q(bad ? ~qs[k] ^ 32'h0000_0001 : ~qs[k], 1'b0, err);
    end
    @(posedge clk_in);
    sid_end_out <= 1'b1;
    @(posedge clk_in);
    sid_end_out <= 1'b0;
  endtask : sid_phase
endmodule : pcs_phy_model
